// >>> pkg/spf_pkg.sv
// Purpose: Shared constants for the serial packet client framer.
// Assumes: One 20 MHz clock; byte link partner runs on the same clock.
// Notes: Packet order is marker, checksum, routine, length, payload.
package spf_pkg;
  localparam logic [7:0] FRAME_BEGIN_MARKER = 8'hAC;
  localparam logic [7:0] PARAM_PAYLOAD_COUNT = 8'h05;
  localparam logic [7:0] CALL_FIRST = 8'h01;
  localparam logic [7:0] CALL_LAST = 8'h28;
  localparam logic [7:0] SYSTEM_INFO_CALL = 8'h02;
  localparam logic [7:0] PORT_INFO_CALL = 8'h08;
  localparam logic [7:0] SYSTEM_RESET_CALL = 8'h0E;
  localparam logic [7:0] FACTORY_RESTORE_CALL = 8'h0F;
  localparam logic [7:0] EVENT_FETCH_CALL = 8'h28;
  // Byte positions of an outgoing parameter packet.
  localparam logic [3:0] TX_POS_MARKER = 4'h0;
  localparam logic [3:0] TX_POS_SUM = 4'h1;
  localparam logic [3:0] TX_POS_ROUTINE = 4'h2;
  localparam logic [3:0] TX_POS_COUNT = 4'h3;
  localparam logic [3:0] TX_POS_PBYTE = 4'h4;
  localparam logic [3:0] TX_POS_LAST = 4'h8;
  // Response timeout: one second at the 20 MHz clock.
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RESP_TIMEOUT_MS = 1000;
  localparam int unsigned RESP_TIMEOUT_CYCLES = RESP_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned FIFO_DEPTH_DEFAULT = 8;
  localparam int unsigned FIFO_WIDTH_DEFAULT = 8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : spf_pkg

// >>> design/spf_fifo.sv
// Purpose: Small synchronous FIFO for received payload bytes.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Level is exported so the producer can throttle ahead of time.
module spf_fifo #(
  parameter int unsigned WIDTH = spf_pkg::FIFO_WIDTH_DEFAULT,
  parameter int unsigned DEPTH = spf_pkg::FIFO_DEPTH_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Status
  output logic [$clog2(DEPTH+1)-1:0] level
);
  import spf_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);

  // Pointers wrap on their own only when the depth is a power of two.
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
    $error("spf_fifo: DEPTH must be a power of two of at least 4");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_next;
  logic [$clog2(DEPTH+1)-1:0] count_q;
  logic [$clog2(DEPTH+1)-1:0] count_d;
  logic [WIDTH-1:0] head_q;
  logic valid_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = valid_q;
  assign out_data = head_q;
  assign rd_next = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
  assign level = count_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
    end
  end

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // The head is a register so the drain side sees flop outputs; a byte written
  // into the slot that becomes the head is forwarded instead of read back.
  always_ff @(posedge clk) begin
    if (reset) begin
      head_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= (count_d != '0);
      if (push && (rd_next == wr_ptr_q)) begin
        head_q <= in_data;
      end else begin
        head_q <= mem_q[rd_next];
      end
    end
  end
endmodule : spf_fifo

// >>> design/spf_timer.sv
// Purpose: Response watchdog counting a fixed number of clock cycles.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Expire is a one-cycle pulse; the timer then stops until restarted.
module spf_timer #(
  parameter int unsigned COUNT = spf_pkg::RESP_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic start,
  input wire logic stop,
  // Result
  output logic expire
);
  import spf_pkg::*;

  if (COUNT < 2) begin : g_bad_count
    $error("spf_timer: COUNT must be at least 2");
  end

  logic [31:0] left_q;
  logic run_q;
  logic expire_q;

  assign expire = expire_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      left_q <= '0;
      run_q <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (start) begin
        left_q <= COUNT[31:0] - 32'h0000_0001;
        run_q <= 1'b1;
      end else if (stop) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (left_q == '0) begin
          run_q <= 1'b0;
          expire_q <= 1'b1;
        end else begin
          left_q <= left_q - 32'h0000_0001;
        end
      end
    end
  end
endmodule : spf_timer

// >>> design/spf_client.sv
// Purpose: Packet client that frames calls to the power manager and parses its replies.
// Assumes: Byte link partner is logic on the same clock with valid/ready handshakes.
// Notes: Reply payload bytes stream through a FIFO; the verdict follows at packet end.
module spf_client #(
  parameter int unsigned TIMEOUT_CYCLES = spf_pkg::RESP_TIMEOUT_CYCLES,
  parameter int unsigned FIFO_DEPTH = spf_pkg::FIFO_DEPTH_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Call request from the user
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_routine,
  input wire logic [7:0] req_param_byte,
  input wire logic [31:0] req_param_word,
  output logic req_reject,
  // Bytes towards the device
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Bytes from the device
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  // Reply payload stream
  output logic resp_data_valid,
  input wire logic resp_data_ready,
  output logic [7:0] resp_data,
  // Reply verdict
  output logic resp_done,
  output logic resp_ok,
  output logic resp_fail,
  output logic resp_timeout,
  output logic [7:0] resp_routine,
  output logic [7:0] resp_count,
  output logic resp_params_valid,
  output logic [7:0] resp_param_byte,
  output logic [31:0] resp_param_word
);
  import spf_pkg::*;

  if (FIFO_DEPTH < 4) begin : g_bad_depth
    $error("spf_client: FIFO_DEPTH must be at least 4");
  end

  typedef enum logic [0:0] {SPF_TX_IDLE, SPF_TX_SEND} spf_tx_e;
  typedef enum logic [2:0] {SPF_RX_HUNT, SPF_RX_SUM, SPF_RX_ROUTINE, SPF_RX_COUNT,
                            SPF_RX_DATA} spf_rx_e;

  function automatic logic [7:0] spf_word_byte(input logic [31:0] w, input logic [1:0] i);
    spf_word_byte = w[8*(3-i) +: 8];
  endfunction : spf_word_byte

  function automatic logic spf_call_valid(input logic [7:0] code);
    spf_call_valid = (code >= CALL_FIRST) && (code <= CALL_LAST);
  endfunction : spf_call_valid

  function automatic logic spf_param_layout(input logic [7:0] code);
    spf_param_layout = (code != SYSTEM_INFO_CALL) && (code != PORT_INFO_CALL) &&
                       (code != EVENT_FETCH_CALL);
  endfunction : spf_param_layout

  spf_tx_e tx_state_q;
  spf_rx_e rx_state_q;
  logic [3:0] tx_pos_q;
  logic [7:0] tx_routine_q;
  logic [7:0] tx_sum_q;
  logic [7:0] tx_pbyte_q;
  logic [31:0] tx_pword_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic req_ready_q;
  logic req_reject_q;
  logic pending_q;
  logic [7:0] sent_routine_q;
  logic [7:0] rx_sum_q;
  logic [7:0] rx_routine_q;
  logic [7:0] rx_left_q;
  logic [7:0] rx_count_q;
  logic [7:0] rx_idx_q;
  logic [7:0] rx_pbyte_q;
  logic [31:0] rx_pword_q;
  logic rx_ready_q;
  logic resp_done_q;
  logic resp_ok_q;
  logic resp_fail_q;
  logic resp_params_valid_q;
  logic [7:0] resp_routine_q;
  logic [7:0] resp_count_q;
  logic [7:0] resp_param_byte_q;
  logic [31:0] resp_param_word_q;
  logic req_take;
  logic tx_take;
  logic rx_take;
  logic fifo_push;
  logic timer_expire;
  logic [7:0] req_sum;
  logic [7:0] rx_sum_d;
  logic rx_finish;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;

  assign req_take = req_valid && req_ready_q;
  assign tx_take = tx_valid_q && tx_ready;
  assign rx_take = rx_valid && rx_ready_q;
  assign rx_sum_d = rx_sum_q + rx_data;
  assign fifo_push = rx_take && (rx_state_q == SPF_RX_DATA);
  // A packet ends on its last payload byte, or on the length byte when it is zero.
  assign rx_finish = rx_take && (((rx_state_q == SPF_RX_COUNT) && (rx_data == 8'h00)) ||
                                 ((rx_state_q == SPF_RX_DATA) && (rx_left_q == 8'h01)));
  // Checksum for a parameter packet covers routine, length, byte and word.
  assign req_sum = 8'h00 - (req_routine + PARAM_PAYLOAD_COUNT + req_param_byte +
                            req_param_word[31:24] + req_param_word[23:16] +
                            req_param_word[15:8] + req_param_word[7:0]);

  assign req_ready = req_ready_q;
  assign req_reject = req_reject_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign rx_ready = rx_ready_q;
  assign resp_done = resp_done_q;
  assign resp_ok = resp_ok_q;
  assign resp_fail = resp_fail_q;
  assign resp_routine = resp_routine_q;
  assign resp_count = resp_count_q;
  assign resp_params_valid = resp_params_valid_q;
  assign resp_param_byte = resp_param_byte_q;
  assign resp_param_word = resp_param_word_q;

  // Request intake; a new call is only taken once the previous one is settled.
  always_ff @(posedge clk) begin
    if (reset) begin
      req_ready_q <= 1'b0;
      req_reject_q <= 1'b0;
      tx_routine_q <= RESET_BYTE;
      tx_sum_q <= RESET_BYTE;
      tx_pbyte_q <= RESET_BYTE;
      tx_pword_q <= RESET_WORD;
    end else begin
      req_reject_q <= 1'b0;
      req_ready_q <= (tx_state_q == SPF_TX_IDLE) && !pending_q && !req_take;
      if (req_take) begin
        req_ready_q <= 1'b0;
        req_reject_q <= !spf_call_valid(req_routine);
        tx_routine_q <= req_routine;
        tx_sum_q <= req_sum;
        tx_pbyte_q <= req_param_byte;
        tx_pword_q <= req_param_word;
      end
    end
  end

  // Transmit sequencer: nine bytes, marker first, word most significant byte first.
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state_q <= SPF_TX_IDLE;
      tx_pos_q <= TX_POS_MARKER;
      tx_valid_q <= 1'b0;
      tx_data_q <= RESET_BYTE;
    end else begin
      unique case (tx_state_q)
        SPF_TX_IDLE: begin
          if (req_take && spf_call_valid(req_routine)) begin
            tx_state_q <= SPF_TX_SEND;
            tx_pos_q <= TX_POS_MARKER;
            tx_valid_q <= 1'b1;
            tx_data_q <= FRAME_BEGIN_MARKER;
          end
        end
        SPF_TX_SEND: begin
          if (tx_take) begin
            if (tx_pos_q == TX_POS_LAST) begin
              tx_state_q <= SPF_TX_IDLE;
              tx_valid_q <= 1'b0;
            end else begin
              tx_pos_q <= tx_pos_q + 4'h1;
              unique case (tx_pos_q + 4'h1)
                TX_POS_SUM: tx_data_q <= tx_sum_q;
                TX_POS_ROUTINE: tx_data_q <= tx_routine_q;
                TX_POS_COUNT: tx_data_q <= PARAM_PAYLOAD_COUNT;
                TX_POS_PBYTE: tx_data_q <= tx_pbyte_q;
                default: tx_data_q <= spf_word_byte(tx_pword_q,
                                                    2'(tx_pos_q - TX_POS_PBYTE));
              endcase
            end
          end
        end
      endcase
    end
  end

  // Outstanding call tracking; the watchdog abandons a call after one second.
  always_ff @(posedge clk) begin
    if (reset) begin
      pending_q <= 1'b0;
      sent_routine_q <= RESET_BYTE;
    end else begin
      if (req_take && spf_call_valid(req_routine)) begin
        pending_q <= 1'b1;
        sent_routine_q <= req_routine;
      end else if (timer_expire || (rx_finish && pending_q)) begin
        pending_q <= 1'b0;
      end
    end
  end

  // Receive parser.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state_q <= SPF_RX_HUNT;
      rx_sum_q <= RESET_BYTE;
      rx_routine_q <= RESET_BYTE;
      rx_left_q <= RESET_BYTE;
      rx_count_q <= RESET_BYTE;
      rx_idx_q <= RESET_BYTE;
      rx_pbyte_q <= RESET_BYTE;
      rx_pword_q <= RESET_WORD;
    end else if (rx_take) begin
      unique case (rx_state_q)
        SPF_RX_HUNT: begin
          if (rx_data == FRAME_BEGIN_MARKER) begin
            rx_state_q <= SPF_RX_SUM;
            rx_sum_q <= RESET_BYTE;
          end
        end
        SPF_RX_SUM: begin
          rx_sum_q <= rx_sum_d;
          rx_state_q <= SPF_RX_ROUTINE;
        end
        SPF_RX_ROUTINE: begin
          rx_sum_q <= rx_sum_d;
          rx_routine_q <= rx_data;
          rx_state_q <= SPF_RX_COUNT;
        end
        SPF_RX_COUNT: begin
          rx_sum_q <= rx_sum_d;
          rx_left_q <= rx_data;
          rx_count_q <= rx_data;
          rx_idx_q <= RESET_BYTE;
          rx_state_q <= (rx_data == 8'h00) ? SPF_RX_HUNT : SPF_RX_DATA;
        end
        SPF_RX_DATA: begin
          rx_sum_q <= rx_sum_d;
          rx_left_q <= rx_left_q - 8'h01;
          rx_idx_q <= rx_idx_q + 8'h01;
          if (rx_idx_q == 8'h00) begin
            rx_pbyte_q <= rx_data;
          end else if (rx_idx_q <= 8'h04) begin
            rx_pword_q <= {rx_pword_q[23:0], rx_data};
          end
          if (rx_left_q == 8'h01) begin
            rx_state_q <= SPF_RX_HUNT;
          end
        end
      endcase
    end
  end

  // Payload bytes are taken only while the FIFO is sure to have room for one more
  // byte in flight; the ready flop lags the level by a cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_ready_q <= 1'b0;
    end else begin
      rx_ready_q <= (32'(fifo_level) + 32'd2 <= FIFO_DEPTH);
    end
  end

  // Verdict at packet end; replies with nothing outstanding get no verdict, but their payload bytes still enter the FIFO.
  always_ff @(posedge clk) begin
    if (reset) begin
      resp_done_q <= 1'b0;
      resp_ok_q <= 1'b0;
      resp_fail_q <= 1'b0;
      resp_params_valid_q <= 1'b0;
      resp_routine_q <= RESET_BYTE;
      resp_count_q <= RESET_BYTE;
      resp_param_byte_q <= RESET_BYTE;
      resp_param_word_q <= RESET_WORD;
    end else begin
      resp_done_q <= 1'b0;
      resp_ok_q <= 1'b0;
      resp_fail_q <= 1'b0;
      if (rx_finish && pending_q) begin
        resp_done_q <= 1'b1;
        resp_routine_q <= rx_routine_q;
        resp_count_q <= rx_count_q;
        if ((rx_sum_d == 8'h00) && (rx_routine_q == sent_routine_q)) begin
          resp_ok_q <= 1'b1;
          resp_params_valid_q <= spf_param_layout(rx_routine_q) &&
                                 (rx_count_q == PARAM_PAYLOAD_COUNT);
          resp_param_byte_q <= rx_pbyte_q;
          resp_param_word_q <= (rx_state_q == SPF_RX_DATA) ?
                               {rx_pword_q[23:0], rx_data} : rx_pword_q;
        end else begin
          resp_fail_q <= 1'b1;
          resp_params_valid_q <= 1'b0;
        end
      end else if (req_take) begin
        resp_params_valid_q <= 1'b0;
      end
    end
  end

  spf_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_push),
    .in_ready(),
    .in_data(rx_data),
    .out_valid(resp_data_valid),
    .out_ready(resp_data_ready),
    .out_data(resp_data),
    .level(fifo_level)
  );

  spf_timer #(
    .COUNT(TIMEOUT_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .start(req_take && spf_call_valid(req_routine)),
    .stop(rx_finish && pending_q),
    .expire(timer_expire)
  );

  assign resp_timeout = timer_expire;
endmodule : spf_client

// >>> test/spf_client_properties.sv
// Purpose: Concurrent checks on the ports of the packet client.
// Assumes: One clock domain; reset is synchronous and active high.
// Notes: Helper counters track the request byte position and the wait since a take.
module spf_client_properties #(
  parameter int unsigned TIMEOUT_CYCLES = 200
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Call request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_routine,
  input wire logic req_reject,
  // Bytes towards the device
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  // Verdict
  input wire logic resp_done,
  input wire logic resp_ok,
  input wire logic resp_fail,
  input wire logic resp_timeout
);
  timeunit 1ns;
  timeprecision 1ns;
  import spf_pkg::*;
  logic take;
  logic [3:0] tx_pos_q;
  logic [31:0] wait_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  assign take = req_valid && req_ready;
  always_ff @(posedge clk) begin
    if (reset || take) begin
      tx_pos_q <= 4'h0;
    end else if (tx_valid && tx_ready && tx_pos_q != 4'hF) begin
      tx_pos_q <= tx_pos_q + 4'h1;
    end
  end
  // The wait count starts at one in the cycle after the take edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= 32'h0000_0000;
    end else if (take) begin
      wait_q <= 32'h0000_0001;
    end else if (wait_q != 32'h0000_0000) begin
      wait_q <= wait_q + 32'h0000_0001;
    end
  end
  a_reject_no_send: assert property (
    take && (req_routine == 8'h00 || req_routine > CALL_LAST) |=> req_reject && !tx_valid)
    else $error("Invalid call code was not refused.");
  a_first_marker: assert property (
    take && req_routine >= CALL_FIRST && req_routine <= CALL_LAST
      |=> tx_valid && tx_data == FRAME_BEGIN_MARKER && !req_reject)
    else $error("Request did not open with the marker byte.");
  a_tx_holds: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("Request byte changed before it was taken.");
  a_len_five: assert property (
    tx_valid && tx_ready && tx_pos_q == TX_POS_COUNT |-> tx_data == PARAM_PAYLOAD_COUNT)
    else $error("Length byte of a request is not five.");
  a_tx_ends: assert property (
    tx_valid && tx_ready && tx_pos_q == TX_POS_LAST |=> !tx_valid)
    else $error("Request ran past its ninth byte.");
  a_busy_after: assert property (
    take |=> !req_ready)
    else $error("A second call could be taken while one is pending.");
  a_verdict_pair: assert property (
    resp_done |-> resp_ok ^ resp_fail)
    else $error("Verdict is not exactly one of ok or fail.");
  a_ok_in_done: assert property (
    resp_ok || resp_fail |-> resp_done)
    else $error("Ok or fail pulsed without done.");
  a_timeout_late: assert property (
    resp_timeout |-> wait_q == TIMEOUT_CYCLES + 1 && !resp_done)
    else $error("Timeout pulse at the wrong moment.");
endmodule : spf_client_properties

bind spf_client spf_client_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .clk, .reset, .req_valid, .req_ready, .req_routine, .req_reject, .tx_valid, .tx_ready,
  .tx_data, .resp_done, .resp_ok, .resp_fail, .resp_timeout);

// >>> test/spf_dev_model.sv
// Purpose: Behavioural power manager that serves calls from the packet client.
// Assumes: Same clock as the client; mode and slow change only between calls.
// Notes: Modes 1 to 5 corrupt, mislabel, withhold, prefix or lengthen the reply.
module spf_dev_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Request bytes
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Reply bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // Behaviour
  input wire logic [2:0] mode,
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  import spf_pkg::*;
  logic [7:0] req[$];
  initial tx_ready = 1'b0;
  always @(posedge clk) begin
    tx_ready <= !reset && (!slow || !tx_ready);
    if (tx_valid && tx_ready) begin
      req.push_back(tx_data);
    end
  end
  task automatic send(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    do @(posedge clk); while (!rx_ready);
    if (slow) begin
      // A released line must not keep showing the byte just taken.
      rx_valid <= 1'b0;
      rx_data <= ~b;
      repeat (3) @(posedge clk);
    end
  endtask : send
  initial begin : serve
    logic [7:0] sum;
    logic [7:0] pb;
    logic [31:0] w;
    logic [7:0] rt;
    logic [7:0] bd[$];
    rx_valid = 1'b0;
    rx_data = 8'h00;
    forever begin
      @(posedge clk);
      while (req.size() > 0 && req[0] !== FRAME_BEGIN_MARKER) begin
        void'(req.pop_front());
      end
      if (req.size() >= 9) begin
        sum = 8'h00;
        for (int i = 1; i < 9; i++) begin
          sum += req[i];
        end
        rt = req[2];
        pb = req[4];
        w = {req[5], req[6], req[7], req[8]};
        req = req[9:$];
        // Bad sums and unknown calls are dropped without any answer.
        if (sum == 8'h00 && rt >= CALL_FIRST && rt <= CALL_LAST && mode != 3'd3) begin
          bd = {(mode == 3'd2) ? rt + 8'h01 : rt};
          if (mode == 3'd5) begin
            bd.push_back(8'd20);
            for (int i = 0; i < 20; i++) begin
              bd.push_back(8'h10 + 8'(i));
            end
          end else begin
            bd = {bd, PARAM_PAYLOAD_COUNT, ~pb, ~w[31:24], ~w[23:16], ~w[15:8], ~w[7:0]};
          end
          sum = 8'h00;
          foreach (bd[i]) begin
            sum -= bd[i];
          end
          if (mode == 3'd1) begin
            sum += 8'h01;
          end
          if (mode == 3'd4) begin
            send(8'h3C);
            send(8'hA5);
          end
          send(FRAME_BEGIN_MARKER);
          send(sum);
          foreach (bd[i]) begin
            send(bd[i]);
          end
          if (!slow) begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
          end
        end
      end
    end
  end
endmodule : spf_dev_model

// >>> test/spf_client_tb.sv
// Purpose: Self-checking bench for the packet client against a device model.
// Assumes: Timeout shortened to 200 cycles; payload FIFO of 8 bytes.
// Notes: Expected bytes and fields are rebuilt here from the request values.
module spf_client_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import spf_pkg::*;
  localparam int unsigned TMO = 200;
  logic clk, reset, req_valid, req_ready, req_reject, tx_valid, tx_ready;
  logic rx_valid, rx_ready, resp_data_valid, resp_data_ready, slow;
  logic resp_done, resp_ok, resp_fail, resp_timeout, resp_params_valid;
  logic [7:0] req_routine, req_param_byte, tx_data, rx_data, resp_data;
  logic [7:0] resp_routine, resp_count, resp_param_byte;
  logic [31:0] req_param_word, resp_param_word;
  logic [2:0] mode;
  logic [7:0] txq[$];
  logic [7:0] rdq[$];
  int err_total, checked, cycles, rx_low;
  spf_client #(.TIMEOUT_CYCLES(TMO), .FIFO_DEPTH(8)) DUT (
    .clk, .reset, .req_valid, .req_ready, .req_routine, .req_param_byte, .req_param_word,
    .req_reject, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .resp_data_valid, .resp_data_ready, .resp_data, .resp_done, .resp_ok, .resp_fail,
    .resp_timeout, .resp_routine, .resp_count, .resp_params_valid, .resp_param_byte,
    .resp_param_word);
  spf_dev_model u_dev (.clk, .reset, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready,
    .rx_data, .mode, .slow);
  task automatic end_of_test;
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // The ceiling sits well above the few thousand cycles the scenarios need.
  always @(posedge clk) begin
    cycles++;
    if (tx_valid && tx_ready) txq.push_back(tx_data);
    if (resp_data_valid && resp_data_ready) rdq.push_back(resp_data);
    if (!rx_ready) rx_low++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic issue(input logic [7:0] rt, input logic [7:0] pb, input logic [31:0] w);
    int n;
    n = 0;
    txq = {};
    rdq = {};
    req_valid <= 1'b1;
    req_routine <= rt;
    req_param_byte <= pb;
    req_param_word <= w;
    do begin
      @(posedge clk);
      n++;
    end while (!req_ready && n < 1000);
    req_valid <= 1'b0;
  endtask : issue
  // Returns reject, timeout, done, ok and fail as seen in the first cycle any is high.
  task automatic wait_end(output logic [4:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      v = {req_reject, resp_timeout, resp_done, resp_ok, resp_fail};
    end while (v == 5'b00000 && n < 600);
    repeat (2) @(posedge clk);
  endtask : wait_end
  task automatic t_call(input logic [7:0] rt, input logic [7:0] pb, input logic [31:0] w);
    logic [4:0] v;
    logic [7:0] e[$];
    logic [7:0] eb;
    logic [31:0] ew;
    e = {FRAME_BEGIN_MARKER, 8'h00, rt, PARAM_PAYLOAD_COUNT, pb,
         w[31:24], w[23:16], w[15:8], w[7:0]};
    for (int i = 2; i < 9; i++) e[1] -= e[i];
    eb = ~pb;
    ew = ~w;
    issue(rt, pb, w);
    wait_end(v);
    chk(v, 5'b00110);
    chk(txq.size(), 9);
    foreach (e[i]) chk(txq[i], e[i]);
    chk(resp_routine, rt);
    chk(resp_count, 8'd5);
    chk(resp_params_valid, !(rt == 8'd2 || rt == 8'd8 || rt == 8'd40));
    chk(resp_param_byte, eb);
    chk(resp_param_word, ew);
    chk(rdq.size(), 5);
  endtask : t_call
  task automatic t_bad(input logic [2:0] m, input logic [4:0] exp);
    logic [4:0] v;
    mode <= m;
    issue(8'd7, 8'h03, 32'h1234_5678);
    wait_end(v);
    chk(v, exp);
    chk(resp_params_valid, 1'b0);
    mode <= 3'd0;
    @(posedge clk);
  endtask : t_bad
  task automatic t_long;
    logic [4:0] v;
    int base;
    mode <= 3'd5;
    resp_data_ready <= 1'b0;
    issue(8'd40, 8'h00, 32'h0000_0000);
    base = rx_low;
    repeat (60) @(posedge clk);
    chk(rx_low - base > 20, 1'b1);
    resp_data_ready <= 1'b1;
    wait_end(v);
    // Up to a FIFO's worth of payload is still queued when the verdict pulses.
    repeat (10) @(posedge clk);
    chk(v, 5'b00110);
    chk(resp_count, 8'd20);
    chk(resp_params_valid, 1'b0);
    chk(rdq.size(), 20);
    foreach (rdq[i]) chk(rdq[i], 8'h10 + i);
    mode <= 3'd0;
  endtask : t_long
  task automatic t_reject(input logic [7:0] rt);
    logic [4:0] v;
    issue(rt, 8'h00, 32'h0000_0000);
    wait_end(v);
    chk(v, 5'b10000);
    chk(txq.size(), 0);
  endtask : t_reject
  initial begin : main
    logic [7:0] rt;
    reset = 1'b1;
    req_valid = 1'b0;
    req_routine = 8'h00;
    req_param_byte = 8'h00;
    req_param_word = 32'h0000_0000;
    resp_data_ready = 1'b1;
    mode = 3'd0;
    slow = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    for (rt = 8'd1; rt <= 8'd40; rt++) begin
      slow <= rt[0];
      t_call(rt, rt ^ 8'hF0, {rt, 8'hC3, 8'h3C, ~rt});
    end
    slow <= 1'b0;
    t_reject(8'd0);
    t_reject(8'd41);
    t_reject(8'hFF);
    t_bad(3'd1, 5'b00101);
    t_bad(3'd2, 5'b00101);
    t_bad(3'd3, 5'b01000);
    mode <= 3'd4;
    t_call(8'd17, 8'hFF, 32'hFFFF_FFFF);
    t_long();
    end_of_test();
  end
endmodule : spf_client_tb
